/* hw/watchdog_timer_sleep_aware.sv */
// Sleep-aware watchdog timer with an APB register slave.
// Assumes the core drives clear, sleep and wake pulses synchronous to pclk.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "wdt_defines.svh"

module watchdog_timer_sleep_aware (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core and oscillator side
  input  wire logic [1:0]  wd_mode_config,
  input  wire logic        clear_watchdog_instr,
  input  wire logic        sleep_enter,
  input  wire logic        wake_event,
  input  wire logic        osc_fail,
  input  wire logic        osc_startup_running,
  input  wire logic        sys_clk_is_crystal,
  // Watchdog results
  output logic             wd_reset,
  output logic             wd_wake,
  output logic             device_asleep,
  output logic             expiry_flag_n,
  output logic             sleep_flag_n,
  output logic             wd_reset_flag_n
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  localparam logic [10:0] TICK_LAST = 11'(`WDT_TICK_DIV - 1);

  // Last count before expiry for a period code; reserved codes fall back to 1:32.
  function automatic logic [22:0] term_of(input logic [4:0] code);
    logic [4:0] e;
    e = (code > `WDT_PS_LAST_VALID) ? 5'h00 : code;
    term_of = (`WDT_PS_BASE_SHIFT << e) - 23'h000001;
  endfunction : term_of

  function automatic logic wd_active(input logic [1:0] mode, input logic swen,
                                     input logic asleep);
    case (wdt_pkg::wd_mode_t'(mode))
      wdt_pkg::WD_MODE_ALWAYS:   wd_active = 1'b1;
      wdt_pkg::WD_MODE_AWAKE:    wd_active = !asleep;
      wdt_pkg::WD_MODE_SOFTWARE: wd_active = swen;
      default:                   wd_active = 1'b0;
    endcase
  endfunction : wd_active

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  wdt_pkg::wdt_state_t q;
  wdt_pkg::wdt_state_t n;

  logic        asleep;
  logic        active;
  logic        expire;
  logic        exit_now;
  logic        hold_clear;
  logic        setup;
  logic        access;
  logic        hit_ctl;
  logic        hit_sts;
  logic        hit_power_control_reg;

  assign asleep   = (q.pwr == wdt_pkg::PWR_ASLEEP);
  assign active   = wd_active(wd_mode_config, q.sw_wd_enable, asleep);
  assign setup    = psel && !penable;
  assign access   = psel && penable && q.pready;
  assign hit_ctl  = (paddr == `WDT_OFF_CONTROL);
  assign hit_sts  = (paddr == `WDT_OFF_STATUS);
  assign hit_power_control_reg = (paddr == `WDT_OFF_POWER_CTRL);

  // The start-up timer keeps the count at zero both after reset and after a
  // crystal wake; non-crystal clocks never see it running on exit.
  assign hold_clear = osc_startup_running && (sys_clk_is_crystal || !asleep);

  // Expiry is judged on the count before this cycle's update; every clear of this cycle,
  // from the core, osc_fail or the start-up timer, wins over a late expiry.
  assign expire = active && q.tick && (q.cnt == term_of(q.wd_period_select)) &&
                  !clear_watchdog_instr && !osc_fail && !hold_clear &&
                  !sleep_enter && !wake_event;
  assign exit_now = asleep && (wake_event || expire);

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    n          = q;
    n.wd_reset = 1'b0;
    n.wd_wake  = 1'b0;
    n.tick     = 1'b0;

    // Low-frequency time base derived from pclk.
    if (q.div == TICK_LAST) begin
      n.div  = 11'h000;
      n.tick = 1'b1;
    end else begin
      n.div = q.div + 11'h001;
    end

    // Sleep sequencing.
    case (q.pwr)
      wdt_pkg::PWR_AWAKE: begin
        if (sleep_enter) begin
          n.pwr           = wdt_pkg::PWR_ASLEEP;
          n.expiry_flag_n = 1'b1;
          n.sleep_flag_n  = 1'b0;
        end
      end
      wdt_pkg::PWR_ASLEEP: begin
        if (exit_now) begin
          n.pwr = wdt_pkg::PWR_AWAKE;
        end
      end
      default: n.pwr = wdt_pkg::PWR_AWAKE;
    endcase

    if (clear_watchdog_instr) begin
      n.expiry_flag_n = 1'b1;
      n.sleep_flag_n  = 1'b1;
    end

    // Counter. The oscillator divider setting has no path into this logic.
    if (!active || clear_watchdog_instr || osc_fail || hold_clear) begin
      n.cnt = 23'h000000;
    end else if (sleep_enter && !asleep) begin
      n.cnt = 23'h000000;
    end else if (exit_now) begin
      n.cnt = 23'h000000;
    end else if (expire) begin
      n.cnt = 23'h000000;
    end else if (q.tick) begin
      n.cnt = q.cnt + 23'h000001;
    end

    // APB access: no wait states, writes land at the completing edge.
    n.pready = 1'b0;
    if (setup) begin
      n.pready  = 1'b1;
      n.pslverr = !(hit_ctl || hit_sts || hit_power_control_reg);
      n.prdata  = 32'h00000000;
      if (hit_ctl) begin
        n.prdata[`WDT_CTL_PS_MSB:`WDT_CTL_PS_LSB] = q.wd_period_select;
        n.prdata[`WDT_CTL_SWEN_BIT]               = q.sw_wd_enable;
      end else if (hit_sts) begin
        n.prdata[`WDT_STS_EXPIRY_BIT] = q.expiry_flag_n;
        n.prdata[`WDT_STS_SLEEP_BIT]  = q.sleep_flag_n;
      end else if (hit_power_control_reg) begin
        n.prdata[`WDT_POWER_CONTROL_REG_RST_BIT] = q.wd_reset_flag_n;
      end
    end
    if (access && pwrite && hit_ctl) begin
      n.wd_period_select = pwdata[`WDT_CTL_PS_MSB:`WDT_CTL_PS_LSB];
      n.sw_wd_enable     = pwdata[`WDT_CTL_SWEN_BIT];
    end
    if (access && pwrite && hit_power_control_reg && pwdata[`WDT_POWER_CONTROL_REG_RST_BIT]) begin
      n.wd_reset_flag_n = 1'b1;
    end

    // Expiry outcome; placed last so hardware wins over a software write.
    if (expire) begin
      n.expiry_flag_n = 1'b0;
      if (asleep) begin
        n.wd_wake = 1'b1;
      end else begin
        n.wd_reset        = 1'b1;
        n.wd_reset_flag_n = 1'b0;
        n.sleep_flag_n    = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q                  <= '0;
      q.pwr              <= wdt_pkg::PWR_AWAKE;
      q.wd_period_select <= `WDT_PS_RESET;
      q.expiry_flag_n    <= 1'b1;
      q.sleep_flag_n     <= 1'b1;
      q.wd_reset_flag_n  <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign prdata          = q.prdata;
  assign pready          = q.pready;
  assign pslverr         = q.pslverr;
  assign wd_reset        = q.wd_reset;
  assign wd_wake         = q.wd_wake;
  assign device_asleep   = asleep;
  assign expiry_flag_n   = q.expiry_flag_n;
  assign sleep_flag_n    = q.sleep_flag_n;
  assign wd_reset_flag_n = q.wd_reset_flag_n;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sleep_entry_clear: assert property (
    !asleep && sleep_enter |=> q.cnt == 23'h000000 && asleep)
    else $error("counter not cleared on sleep entry");

  a_wake_clear: assert property (
    asleep && wake_event |=> q.cnt == 23'h000000 && !asleep)
    else $error("counter not cleared on wake");

  a_ost_hold: assert property (
    osc_startup_running && (sys_clk_is_crystal || !asleep) |=> q.cnt == 23'h000000)
    else $error("counter moved while start-up timer ran");

  a_sleep_no_reset: assert property (
    asleep |=> !q.wd_reset)
    else $error("reset raised while asleep");

  a_expiry_flags: assert property (
    q.wd_reset |-> !q.expiry_flag_n && q.sleep_flag_n)
    else $error("flags wrong after awake expiry");

  a_reset_record: assert property (
    q.wd_reset |-> !q.wd_reset_flag_n)
    else $error("reset source not recorded");

  a_mode_off: assert property (
    wd_mode_config == 2'b00 || (wd_mode_config == 2'b01 && !q.sw_wd_enable)
    |=> q.cnt == 23'h000000 || $past(wd_mode_config) != wd_mode_config)
    else $error("counter ran while disabled");

  a_mode10_sleep: assert property (
    asleep && wd_mode_config == 2'b10 && $stable(wd_mode_config)[*2]
    |-> q.cnt == 23'h000000)
    else $error("counter ran in sleep with mode 10");

  a_reserved_min: assert property (
    active && q.wd_period_select > 5'h12 && q.cnt == 23'h00001f && q.tick
    && !clear_watchdog_instr && !osc_fail && !hold_clear && !sleep_enter && !wake_event
    |=> q.wd_reset || q.wd_wake)
    else $error("reserved period did not expire at 1:32");

  a_clear_instr: assert property (
    clear_watchdog_instr |=> q.cnt == 23'h000000 && q.expiry_flag_n && !q.wd_reset)
    else $error("clear instruction had no effect");

  a_tick_spacing: assert property (
    q.tick |=> !q.tick [*8])
    else $error("time base ticks too close");

  a_bits_zero: assert property (
    q.pready && paddr == `WDT_OFF_CONTROL |-> q.prdata[31:6] == 26'h0000000)
    else $error("unimplemented control bits read nonzero");

  c_awake_expiry: cover property (q.wd_reset);
  c_sleep_wake:   cover property (q.wd_wake);
  c_apb_write:    cover property (access && pwrite && hit_ctl);
  c_crystal_hold: cover property (asleep && sys_clk_is_crystal && osc_startup_running);

endmodule : watchdog_timer_sleep_aware

/* hw/wdt_defines.svh */
// Offsets, field positions, reset values and timing counts of the sleep-aware watchdog.
// Assumes a 40 MHz pclk and byte addresses on an APB bus with 32-bit data.
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define WDT_OFF_CONTROL     8'h00
`define WDT_OFF_STATUS      8'h04
`define WDT_OFF_POWER_CTRL  8'h08

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define WDT_CTL_SWEN_BIT    0
`define WDT_CTL_PS_LSB      1
`define WDT_CTL_PS_MSB      5
`define WDT_STS_SLEEP_BIT   0
`define WDT_STS_EXPIRY_BIT  1
`define WDT_POWER_CONTROL_REG_RST_BIT    0

// ----------------------------------------------------------------------------
// Reset values and period codes
// ----------------------------------------------------------------------------
`define WDT_PS_RESET        5'h0b
`define WDT_PS_LAST_VALID   5'h12
`define WDT_PS_BASE_SHIFT   23'h000020

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDT_PCLK_HZ         40000000
`define WDT_LFOSC_HZ        31000
`define WDT_TICK_DIV        (`WDT_PCLK_HZ / `WDT_LFOSC_HZ)

`endif

/* hw/wdt_pkg.sv */
// Types shared by the sleep-aware watchdog.
// Assumes the defines header is compiled alongside.
package wdt_pkg;

  typedef enum logic [0:0] {
    PWR_AWAKE  = 1'b0,
    PWR_ASLEEP = 1'b1
  } pwr_state_t;

  typedef enum logic [1:0] {
    WD_MODE_OFF      = 2'b00,
    WD_MODE_SOFTWARE = 2'b01,
    WD_MODE_AWAKE    = 2'b10,
    WD_MODE_ALWAYS   = 2'b11
  } wd_mode_t;

  typedef struct packed {
    logic [10:0]        div;
    logic               tick;
    logic [22:0]        cnt;
    pwr_state_t         pwr;
    logic [4:0]         wd_period_select;
    logic               sw_wd_enable;
    logic               expiry_flag_n;
    logic               sleep_flag_n;
    logic               wd_reset_flag_n;
    logic               wd_reset;
    logic               wd_wake;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } wdt_state_t;

endpackage : wdt_pkg

/* verification/core_model.sv */
// Processor core model that issues watchdog clear, sleep and wake pulses.
// Assumes a free-running pclk; each pulse lasts one cycle after a rising edge.
`timescale 1ns/10ps

module core_model (
  // Clock
  input  wire logic pclk,
  // Core requests
  output logic      clear_watchdog_instr,
  output logic      sleep_enter,
  output logic      wake_event,
  // Watchdog wake
  input  wire logic wd_wake
);
  int resumed;

  initial begin
    clear_watchdog_instr = 1'b0;
    sleep_enter = 1'b0;
    wake_event = 1'b0;
    resumed = 0;
  end

  // Kind 0 clears, 1 enters Sleep, 2 is an outside wake source.
  task drive(input int k);
    @(posedge pclk);
    clear_watchdog_instr <= (k == 0);
    sleep_enter <= (k == 1);
    wake_event <= (k == 2);
    @(posedge pclk);
    clear_watchdog_instr <= 1'b0;
    sleep_enter <= 1'b0;
    wake_event <= 1'b0;
  endtask : drive

  // The core resumes execution when the watchdog wakes it.
  always @(posedge pclk) if (wd_wake === 1'b1) resumed <= resumed + 1;
endmodule : core_model

/* verification/tb_watchdog_timer_sleep_aware.sv */
// Self-checking bench for the sleep-aware watchdog with an APB master and core model.
// Assumes the core model file and the design defines header are compiled alongside.
`timescale 1ns/10ps
`include "wdt_defines.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end

module tb_watchdog_timer_sleep_aware;
  localparam int TK = `WDT_TICK_DIV;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  wd_mode_config;
  logic        clear_watchdog_instr, sleep_enter, wake_event;
  logic        wd_reset, wd_wake, device_asleep;
  logic        osc_fail, osc_startup_running, sys_clk_is_crystal;
  logic        expiry_flag_n, sleep_flag_n, wd_reset_flag_n;
  int          miscompares, cmp_count, cyc, rst_seen, t0, dt, code;
  int          ctl_m, sts_m, power_control_reg_m;

  watchdog_timer_sleep_aware dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wd_mode_config(wd_mode_config), .clear_watchdog_instr(clear_watchdog_instr),
    .sleep_enter(sleep_enter), .wake_event(wake_event), .osc_fail(osc_fail),
    .osc_startup_running(osc_startup_running), .sys_clk_is_crystal(sys_clk_is_crystal),
    .wd_reset(wd_reset),
    .wd_wake(wd_wake), .device_asleep(device_asleep), .expiry_flag_n(expiry_flag_n),
    .sleep_flag_n(sleep_flag_n), .wd_reset_flag_n(wd_reset_flag_n));

  core_model core_u (
    .pclk(pclk), .clear_watchdog_instr(clear_watchdog_instr),
    .sleep_enter(sleep_enter), .wake_event(wake_event), .wd_wake(wd_wake));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // The cycle count also bounds the whole run.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wd_reset === 1'b1) rst_seen <= rst_seen + 1;
    if (cyc > 96000) begin
      miscompares++;
      end_of_test();
    end
  end

  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) `CHK(pready, 1'b1)
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] a, input int e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e[31:0])
  endtask : rchk

  // Waits for a reset request or a wake pulse; dt is the distance from t0.
  task wait_exp(input bit wake);
    int n;
    n = 0;
    @(posedge pclk);
    while ((wake ? wd_wake : wd_reset) !== 1'b1 && n < 34 * TK) begin
      n++;
      @(posedge pclk);
    end
    dt = cyc - t0;
  endtask : wait_exp

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, wd_mode_config, osc_fail} = '0;
    {osc_startup_running, sys_clk_is_crystal} = '0;
    {miscompares, cmp_count, cyc, rst_seen} = '0;
    code = $urandom(22262);
    ctl_m = {`WDT_PS_RESET, 1'b0};
    sts_m = 3;
    power_control_reg_m = 1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`WDT_OFF_CONTROL, ctl_m);
    rchk(`WDT_OFF_STATUS, sts_m);
    rchk(`WDT_OFF_POWER_CTRL, power_control_reg_m);
    apb(1'b1, 8'h0c, 32'hffffffff);
    `CHK(err, 1'b1)
    rchk(8'h0c, 0);
    apb(1'b1, `WDT_OFF_STATUS, 32'h0);
    rchk(`WDT_OFF_STATUS, sts_m);
    code = 19 + $urandom % 13;
    ctl_m = (code << 1) | 1;
    wd_mode_config <= 2'b11;
    apb(1'b1, `WDT_OFF_CONTROL, ($urandom & 32'hffffffc0) | ctl_m);
    rchk(`WDT_OFF_CONTROL, ctl_m);
    osc_startup_running <= 1'b1;
    sys_clk_is_crystal  <= 1'($urandom % 2);
    core_u.drive(0);
    repeat (2 * TK) @(posedge pclk);
    osc_startup_running <= 1'b0;
    repeat (2 * TK + $urandom % TK) @(posedge pclk);
    `CHK(rst_seen, 0)
    core_u.drive(0);
    t0 = cyc;
    wait_exp(1'b0);
    `CHK(dt >= 31 * TK && dt <= 32 * TK + 4, 1'b1)
    sts_m = 1;
    power_control_reg_m = 0;
    rchk(`WDT_OFF_STATUS, sts_m);
    rchk(`WDT_OFF_POWER_CTRL, power_control_reg_m);
    power_control_reg_m = 1;
    apb(1'b1, `WDT_OFF_POWER_CTRL, 32'h1);
    rchk(`WDT_OFF_POWER_CTRL, power_control_reg_m);
    core_u.drive(0);
    sts_m = 3;
    rchk(`WDT_OFF_STATUS, sts_m);
    ctl_m = 1;
    apb(1'b1, `WDT_OFF_CONTROL, ctl_m);
    core_u.drive(1);
    @(posedge pclk);
    `CHK(device_asleep, 1'b1)
    sts_m = 2;
    rchk(`WDT_OFF_STATUS, sts_m);
    sys_clk_is_crystal  <= 1'b1;
    osc_startup_running <= 1'b1;
    repeat (TK) @(posedge pclk);
    osc_startup_running <= 1'b0;
    repeat (2 * TK) @(posedge pclk);
    osc_fail <= 1'b1;
    @(posedge pclk);
    osc_fail <= 1'b0;
    t0 = cyc;
    wait_exp(1'b1);
    `CHK(dt >= 31 * TK && dt <= 32 * TK + 4, 1'b1)
    repeat (3) @(posedge pclk);
    `CHK(rst_seen, 1)
    `CHK(device_asleep, 1'b0)
    `CHK(core_u.resumed, 1)
    sts_m = 0;
    rchk(`WDT_OFF_STATUS, sts_m);
    rchk(`WDT_OFF_POWER_CTRL, power_control_reg_m);
    wd_mode_config <= 2'b10;
    core_u.drive(1);
    @(posedge pclk);
    `CHK(device_asleep, 1'b1)
    core_u.drive(2);
    repeat (2) @(posedge pclk);
    `CHK(device_asleep, 1'b0)
    end_of_test();
  end
endmodule : tb_watchdog_timer_sleep_aware
